// [sws_pkg.sv]
// Constants and types shared by the scan waveform sequencer
package sws_pkg;
  localparam int unsigned CLK_HZ         = 25000000;
  localparam int unsigned STEP_TICK_NS   = 4000;
  localparam int unsigned HOLD_TICK_NS   = 100000;
  localparam int unsigned STEP_TICK_CYC  = CLK_HZ / 1000 * STEP_TICK_NS / 1000000;
  localparam int unsigned HOLD_TICK_CYC  = CLK_HZ / 1000 * HOLD_TICK_NS / 1000000;
  localparam int unsigned STEP_CNT_W     = 24;
  localparam int unsigned TIME_W         = 32;

  localparam logic [7:0] ADDR_CFG        = 8'h00;
  localparam logic [7:0] ADDR_CMD        = 8'h04;
  localparam logic [7:0] ADDR_T1         = 8'h08;
  localparam logic [7:0] ADDR_T2         = 8'h0C;
  localparam logic [7:0] ADDR_RAMP       = 8'h10;
  localparam logic [7:0] ADDR_STATUS     = 8'h14;

  localparam int unsigned CFG_GALV_BIT   = 3;
  localparam int unsigned CFG_RETAIN_BIT = 4;
  localparam int unsigned CFG_CONT_BIT   = 5;
  localparam int unsigned CFG_EXT_BIT    = 6;
  localparam int unsigned CMD_GO_BIT     = 0;
  localparam int unsigned CMD_PAUSE_BIT  = 1;
  localparam int unsigned CMD_ADV_BIT    = 2;
  localparam int unsigned CMD_STOP_BIT   = 3;
  localparam int unsigned CMD_TRIG_BIT   = 4;

  localparam logic [6:0]  CFG_RESET      = 7'h00;
  localparam logic [31:0] TIME_RESET     = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY      = 2'b00;
  localparam logic [1:0]  RESP_SLVERR    = 2'b10;

  typedef enum logic [2:0] {
    MODE_STEP        = 3'h0,
    MODE_HOLD        = 3'h1,
    MODE_TIMED_HOLD  = 3'h2,
    cyclic_ramp_mode = 3'h3,
    linear_ramp_mode = 3'h4
  } sws_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ARMED,
    ST_WAIT1,
    ST_FWD,
    ST_WAIT2,
    ST_RET,
    ST_HELD
  } sws_state_t;
endpackage

// [sws_top.sv]
// Scan waveform sequencer with AXI4-Lite register slave
//
// Notes on behaviour
// RQ1: Step delays count 24-bit ticks of 4 us each.
// RQ2: Retain end condition drives cell straight back to first setpoint after step program.
// RQ3: Single step or linear program applies end condition when second wait expires.
// RQ4: Continuous step returns to first setpoint after second wait and repeats.
// RQ5: Hold modes accept only open-circuit end and single scan; others rejected.
// RQ6: Hold modes accept only manual trigger; external trigger setting rejected.
// RQ7: Timed hold releases cell control when first hold interval elapses.
// RQ8: Single cyclic program ends when return ramp reaches starting setpoint.
// RQ9: Continuous cyclic reverses at return ramp end and repeats without pause.
// RQ10: Continuous linear ramps back at forward rate after second wait, then repeats.
// RQ11: Galvanostat mode makes cyclic, linear and step programs drive current.
// RQ12: Go starts scan in manual trigger mode, only arms in external mode.
// RQ13: Armed external scan engages cell at once, waits at start for trigger.
// RQ14: Go engages cell only when enable switch on; enable lamp then lights.
// RQ15: Scan trigger comes from go key, rear trigger input or remote interface.
// RQ16: Pause freezes scan at current point; second pause resumes from there.
// RQ17: Advance moves to next stage; cyclic forward ramp to return, return to end.
// RQ18: Stop ends scan and always releases cell control.
// RQ19: At end, open circuit releases control; start setpoint keeps control there.
// RQ20: Cyclic and linear hold times count 100 us ticks below 100 hours.
// RQ21: External trigger is synchronised; only first edge after arming starts scan.
`timescale 1ns/1ps
module sws_top
  import sws_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        key_go,
  input  wire logic        key_pause,
  input  wire logic        key_advance,
  input  wire logic        key_stop,
  input  wire logic        ext_trig_in,
  input  wire logic        enable_switch,
  output logic             cell_enable,
  output logic             enable_lamp,
  output logic             current_control,
  output logic             second_setpoint,
  output logic             ramp_active,
  output logic             ramp_forward,
  output logic [2:0]       scan_stage
);

  sws_state_t  state_reg, state_next;
  logic [6:0]  cfg_reg;
  logic [31:0] t1_reg, t2_reg, ramp_reg;
  logic [31:0] cnt_reg;
  logic [11:0] div_reg;
  logic        cell_on_reg, paused_reg, cfg_err_reg;
  logic        trig_s1_reg, trig_s2_reg, trig_s3_reg;
  logic        aw_have_reg, w_have_reg;
  logic [7:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        do_write, cfg_bad, stage_done, tick, step_like;
  logic        go_p, pause_p, adv_p, stop_p, rtrig_p, ext_edge;
  logic [31:0] limit;
  sws_mode_t   mode;

  assign mode      = sws_mode_t'(cfg_reg[2:0]);
  assign step_like = (mode == MODE_STEP);

  // AXI4-Lite write path: address and data may come in either order
  assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_reg && !s_axi_bvalid;
  assign do_write      = aw_have_reg && w_have_reg && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      w_have_reg  <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end else if (do_write) begin
        aw_have_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end else if (do_write) begin
        w_have_reg <= 1'b0;
      end
    end
  end

  // Hold modes only take open circuit, single scan and manual trigger
  always_comb begin
    cfg_bad = 1'b0;
    if (w_data_reg[2:0] > 3'h4) begin
      cfg_bad = 1'b1;
    end else if (w_data_reg[2:0] == MODE_HOLD || w_data_reg[2:0] == MODE_TIMED_HOLD) begin
      cfg_bad = w_data_reg[CFG_RETAIN_BIT] || w_data_reg[CFG_CONT_BIT] || w_data_reg[CFG_EXT_BIT]; // RQ5 RQ6
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= RESP_OKAY;
      if (aw_addr_reg == ADDR_CFG && cfg_bad) begin
        s_axi_bresp <= RESP_SLVERR;
      end else if (aw_addr_reg > ADDR_STATUS || aw_addr_reg[1:0] != 2'b00 || aw_addr_reg == ADDR_STATUS) begin
        s_axi_bresp <= RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // The CFG register is frozen while a scan runs; T1, T2 and RAMP stay writable under it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_reg     <= CFG_RESET;
      t1_reg      <= TIME_RESET;
      t2_reg      <= TIME_RESET;
      ramp_reg    <= TIME_RESET;
      cfg_err_reg <= 1'b0;
    end else if (do_write && w_strb_reg[0]) begin
      unique case (aw_addr_reg)
        ADDR_CFG: begin
          if (cfg_bad) begin
            cfg_err_reg <= 1'b1; // RQ5 RQ6
          end else if (state_reg == ST_IDLE) begin
            cfg_reg     <= w_data_reg[6:0];
            cfg_err_reg <= 1'b0;
          end
        end
        ADDR_T1:   t1_reg   <= w_data_reg;
        ADDR_T2:   t2_reg   <= w_data_reg;
        ADDR_RAMP: ramp_reg <= w_data_reg;
        default: ;
      endcase
    end
  end

  // Read path answers one cycle after the address is taken
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      unique case (s_axi_araddr)
        ADDR_CFG:    s_axi_rdata <= {25'h0, cfg_reg};
        ADDR_CMD:    s_axi_rdata <= 32'h0000_0000;
        ADDR_T1:     s_axi_rdata <= t1_reg;
        ADDR_T2:     s_axi_rdata <= t2_reg;
        ADDR_RAMP:   s_axi_rdata <= ramp_reg;
        ADDR_STATUS: s_axi_rdata <= {26'h0, cfg_err_reg, paused_reg, cell_on_reg, 3'(state_reg)};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Command sources: front keys or remote command register
  assign go_p    = key_go || (do_write && aw_addr_reg == ADDR_CMD && w_data_reg[CMD_GO_BIT]);
  assign pause_p = key_pause || (do_write && aw_addr_reg == ADDR_CMD && w_data_reg[CMD_PAUSE_BIT]);
  assign adv_p   = key_advance || (do_write && aw_addr_reg == ADDR_CMD && w_data_reg[CMD_ADV_BIT]);
  assign stop_p  = key_stop || (do_write && aw_addr_reg == ADDR_CMD && w_data_reg[CMD_STOP_BIT]);
  assign rtrig_p = do_write && aw_addr_reg == ADDR_CMD && w_data_reg[CMD_TRIG_BIT];

  // Trigger input synchroniser, edge taken from the settled stages only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_s1_reg <= 1'b0;
      trig_s2_reg <= 1'b0;
      trig_s3_reg <= 1'b0;
    end else begin
      trig_s1_reg <= ext_trig_in; // RQ21
      trig_s2_reg <= trig_s1_reg;
      trig_s3_reg <= trig_s2_reg;
    end
  end
  assign ext_edge = trig_s2_reg && !trig_s3_reg;

  // Tick divider stops while paused so the frozen point does not drift
  assign tick = (div_reg == 12'(((step_like) ? STEP_TICK_CYC : HOLD_TICK_CYC) - 1)); // RQ1 RQ20

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_reg <= 12'h000;
    end else if (state_next != state_reg) begin
      div_reg <= 12'h000;
    end else if (!paused_reg) begin
      div_reg <= tick ? 12'h000 : div_reg + 12'h001;
    end
  end

  always_comb begin
    limit = 32'h0000_0000;
    unique case (state_reg)
      ST_WAIT1: limit = step_like ? {8'h00, t1_reg[STEP_CNT_W-1:0]} : t1_reg; // RQ1
      ST_WAIT2: limit = step_like ? {8'h00, t2_reg[STEP_CNT_W-1:0]} : t2_reg; // RQ1
      ST_FWD:   limit = ramp_reg;
      ST_RET:   limit = ramp_reg; // RQ10
      default:  limit = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= 32'h0000_0000;
    end else if (state_next != state_reg) begin
      cnt_reg <= 32'h0000_0000;
    end else if (tick && !paused_reg && cnt_reg < limit) begin
      cnt_reg <= cnt_reg + 32'h0000_0001;
    end
  end

  // A plain hold never times out; it waits for advance or stop
  assign stage_done = !paused_reg && cnt_reg >= limit && mode != MODE_HOLD;

  // Stage sequencing per program
  always_comb begin
    state_next = state_reg;
    if (stop_p) begin
      state_next = ST_IDLE; // RQ18
    end else begin
      unique case (state_reg)
        ST_IDLE, ST_HELD: begin
          if ((go_p || rtrig_p) && enable_switch) begin // RQ14 RQ15
            state_next = (cfg_reg[CFG_EXT_BIT] && !rtrig_p) ? ST_ARMED : // RQ12
                         (mode == cyclic_ramp_mode) ? ST_FWD : ST_WAIT1;
          end
        end
        ST_ARMED: begin
          if (ext_edge || rtrig_p) begin // RQ13 RQ15 RQ21
            state_next = (mode == cyclic_ramp_mode) ? ST_FWD : ST_WAIT1;
          end
        end
        ST_WAIT1: begin
          if (stage_done || adv_p) begin
            unique case (mode)
              MODE_STEP:        state_next = ST_WAIT2;
              MODE_HOLD:        state_next = ST_IDLE;
              MODE_TIMED_HOLD:  state_next = ST_IDLE; // RQ7
              default:          state_next = ST_FWD;
            endcase
          end
        end
        ST_FWD: begin
          if (stage_done || adv_p) begin // RQ17
            state_next = (mode == cyclic_ramp_mode) ? ST_RET : ST_WAIT2;
          end
        end
        ST_WAIT2: begin
          if (stage_done || adv_p) begin
            if (!cfg_reg[CFG_CONT_BIT]) begin
              state_next = cfg_reg[CFG_RETAIN_BIT] ? ST_HELD : ST_IDLE; // RQ2 RQ3 RQ19
            end else begin
              state_next = step_like ? ST_WAIT1 : ST_RET; // RQ4 RQ10
            end
          end
        end
        ST_RET: begin
          if (adv_p || (stage_done && !cfg_reg[CFG_CONT_BIT] && mode == cyclic_ramp_mode)) begin
            state_next = cfg_reg[CFG_RETAIN_BIT] ? ST_HELD : ST_IDLE; // RQ8 RQ17 RQ19
          end else if (stage_done) begin
            state_next = (mode == cyclic_ramp_mode) ? ST_FWD : ST_WAIT1; // RQ9 RQ10
          end
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      paused_reg <= 1'b0;
    end else if (stop_p || state_next == ST_IDLE || state_next == ST_HELD) begin
      paused_reg <= 1'b0;
    end else if (pause_p && state_reg != ST_ARMED && state_reg != ST_IDLE && state_reg != ST_HELD) begin
      paused_reg <= !paused_reg; // RQ16
    end
  end

  // Cell control follows the scan; enable switch off drops it at once
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cell_on_reg <= 1'b0;
    end else begin
      cell_on_reg <= (state_next != ST_IDLE) && enable_switch; // RQ14 RQ18 RQ19
    end
  end

  assign cell_enable     = cell_on_reg;
  assign enable_lamp     = cell_on_reg; // RQ14
  assign current_control = cfg_reg[CFG_GALV_BIT]; // RQ11
  assign second_setpoint = (state_reg == ST_WAIT2);
  assign ramp_active     = (state_reg == ST_FWD) || (state_reg == ST_RET);
  assign ramp_forward    = (state_reg == ST_FWD);
  assign scan_stage      = 3'(state_reg);

  chk_stop_release: assert property (@(posedge aclk) disable iff (!aresetn)
    stop_p |=> !cell_on_reg && state_reg == ST_IDLE) else $error("stop did not release cell"); // RQ18
  chk_armed_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == ST_ARMED && !ext_edge && !rtrig_p && !stop_p |=> state_reg == ST_ARMED)
    else $error("armed scan left start without trigger"); // RQ13
  chk_ext_arm: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == ST_IDLE && go_p && !stop_p && !rtrig_p && enable_switch && cfg_reg[CFG_EXT_BIT]
    |=> state_reg == ST_ARMED && cell_on_reg) else $error("go did not arm"); // RQ12
  chk_no_switch: assert property (@(posedge aclk) disable iff (!aresetn)
    !enable_switch |=> !cell_on_reg) else $error("cell on with switch off"); // RQ14
  chk_pause_freeze: assert property (@(posedge aclk) disable iff (!aresetn)
    paused_reg && !stop_p && !pause_p && !adv_p |=> $stable(cnt_reg) && $stable(state_reg))
    else $error("paused scan moved"); // RQ16
  chk_retain_end: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == ST_WAIT2 && stage_done && !stop_p && !cfg_reg[CFG_CONT_BIT] && cfg_reg[CFG_RETAIN_BIT]
    |=> state_reg == ST_HELD && !second_setpoint) else $error("retain end missed"); // RQ2
  chk_step_repeat: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == ST_WAIT2 && stage_done && !stop_p && step_like && cfg_reg[CFG_CONT_BIT]
    |=> state_reg == ST_WAIT1) else $error("continuous step did not repeat"); // RQ4
  chk_cyc_turn: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == ST_RET && stage_done && !stop_p && !adv_p && mode == cyclic_ramp_mode && cfg_reg[CFG_CONT_BIT]
    |=> state_reg == ST_FWD) else $error("cyclic did not turn around"); // RQ9
  chk_adv_return: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == ST_FWD && adv_p && !stop_p && mode == cyclic_ramp_mode |=> state_reg == ST_RET)
    else $error("advance did not start return ramp"); // RQ17
  chk_hold_cfg: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode == MODE_HOLD || mode == MODE_TIMED_HOLD)
    |-> !cfg_reg[CFG_RETAIN_BIT] && !cfg_reg[CFG_CONT_BIT] && !cfg_reg[CFG_EXT_BIT])
    else $error("illegal hold setup taken"); // RQ5 RQ6
  chk_timed_release: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == ST_WAIT1 && mode == MODE_TIMED_HOLD && stage_done && !stop_p
    |=> state_reg == ST_IDLE && !cell_on_reg) else $error("timed hold kept control"); // RQ7

  cov_ext_start: cover property (@(posedge aclk) disable iff (!aresetn)
    state_reg == ST_ARMED ##1 state_reg == ST_WAIT1);
  cov_pause_resume: cover property (@(posedge aclk) disable iff (!aresetn)
    !paused_reg ##1 paused_reg ##[1:1000] !paused_reg && state_reg != ST_IDLE);
  cov_held_end: cover property (@(posedge aclk) disable iff (!aresetn)
    state_reg == ST_RET ##1 state_reg == ST_HELD);
endmodule

// [sws_panel.sv]
// Model of the front panel keys, rear scan trigger and hardware enable switch
`timescale 1ns/1ps
module sws_panel (
  input  wire logic aclk,
  output logic      key_go,
  output logic      key_pause,
  output logic      key_advance,
  output logic      key_stop,
  output logic      ext_trig_in,
  output logic      enable_switch
);
  initial begin
    {key_go, key_pause, key_advance, key_stop, ext_trig_in} = 5'h00;
    enable_switch = 1'h1;
  end

  // Debounced key gives exactly one cycle per press
  task automatic press(input int k);
    @(posedge aclk);
    case (k)
      0: key_go <= 1'h1;
      1: key_pause <= 1'h1;
      2: key_advance <= 1'h1;
      default: key_stop <= 1'h1;
    endcase
    @(posedge aclk);
    {key_go, key_pause, key_advance, key_stop} <= 4'h0;
  endtask

  // Held for several cycles so the synchroniser cannot miss it
  task automatic fire_trig();
    @(posedge aclk);
    ext_trig_in <= 1'h1;
    repeat (4) @(posedge aclk);
    ext_trig_in <= 1'h0;
  endtask

  task automatic set_switch(input logic on);
    @(posedge aclk);
    enable_switch <= on;
  endtask
endmodule

// [testbench.sv]
// Self-checking bench for the scan waveform sequencer
`timescale 1ns/1ps
module testbench;
  import sws_pkg::*;
  localparam int LIM = 4 * HOLD_TICK_CYC + 50;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, d, rnd_st;
  logic [3:0]  wstrb;
  logic [1:0]  r;
  logic [6:0]  bad [4] = '{7'h11, 7'h21, 7'h41, 7'h12};
  wire         awready, wready, bvalid, arready, rvalid, cell_enable, enable_lamp;
  wire         current_control, second_setpoint, ramp_active, ramp_forward;
  wire         key_go, key_pause, key_advance, key_stop, ext_trig_in, enable_switch;
  wire [1:0]   bresp, rresp;
  wire [31:0]  rdata;
  wire [2:0]   scan_stage;
  int          error_cnt, comparisons, t1, t2;

  sws_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .key_go(key_go),
    .key_pause(key_pause), .key_advance(key_advance), .key_stop(key_stop), .ext_trig_in(ext_trig_in),
    .enable_switch(enable_switch), .cell_enable(cell_enable), .enable_lamp(enable_lamp),
    .current_control(current_control), .second_setpoint(second_setpoint), .ramp_active(ramp_active),
    .ramp_forward(ramp_forward), .scan_stage(scan_stage));
  sws_panel panel_u (.aclk(aclk), .key_go(key_go), .key_pause(key_pause), .key_advance(key_advance),
    .key_stop(key_stop), .ext_trig_in(ext_trig_in), .enable_switch(enable_switch));

  always #20 aclk = ~aclk;

  function automatic logic [31:0] xs();
    rnd_st = rnd_st ^ (rnd_st << 13);
    rnd_st = rnd_st ^ (rnd_st >> 17);
    rnd_st = rnd_st ^ (rnd_st << 5);
    return rnd_st;
  endfunction

  // Reference model: stage that follows s when the current stage runs out
  function automatic int nxt(int m, bit cont, bit ret, int s);
    int endv;
    endv = ret ? 6 : 0;
    if (s < 2) return m == 3 ? 3 : 2;
    case (m)
      0: return s == 2 ? 4 : (cont ? 2 : endv);
      2: return 0;
      3: return s == 3 ? 5 : (cont ? 3 : endv);
      default: return s == 2 ? 3 : s == 3 ? 4 : s == 5 ? 2 : (cont ? 5 : endv);
    endcase
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s saw %0h wanted %0h", $time, what, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (!(bvalid && bready));
    rs = bresp;
    bready <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'h0;
    end while (!(rvalid && rready));
    v = rdata;
    rs = rresp;
    rready <= 1'h0;
  endtask

  task automatic setup(input logic [6:0] c, input int a, input int b, input int rp);
    wr(ADDR_T1, a, r);
    wr(ADDR_T2, b, r);
    wr(ADDR_RAMP, rp, r);
    wr(ADDR_CFG, {25'h0, c}, r);
    chk(r, RESP_OKAY, "cfg accepted");
  endtask

  // Follows the scan through a number of stage changes and checks each one against the model
  task automatic run(input int m, input bit cont, input bit ret, input int steps, input logic [2:0] s0,
                     input int tq);
    int e;
    int n;
    logic [2:0] s;
    s = s0;
    for (int i = 0; i < steps; i++) begin
      e = nxt(m, cont, ret, s);
      n = 0;
      while (scan_stage === s && n < LIM) begin
        @(negedge aclk);
        n++;
      end
      chk({29'h0, scan_stage}, e, "stage");
      if (i == 1 && tq >= 0) chk(n >= tq * STEP_TICK_CYC - 10 && n <= tq * STEP_TICK_CYC + 110, 1, "delay");
      repeat (2) @(negedge aclk);
      chk({27'h0, cell_enable, enable_lamp, second_setpoint, ramp_active, ramp_forward},
          {27'h0, e != 0, e != 0, e == 4, e == 3 || e == 5, e == 3}, "outputs");
      s = e[2:0];
    end
  endtask

  task automatic stop_chk();
    panel_u.press(3);
    @(negedge aclk);
    chk({scan_stage, cell_enable}, 4'h0, "stopped");
  endtask

  task automatic done(input string n);
    $display("test %s finished, %0d mismatches so far", n, error_cnt);
  endtask

  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (80000) @(posedge aclk);
    error_cnt++;
    conclude();
  end

  initial begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
    {awaddr, araddr, wdata} = 48'h0;
    wstrb = 4'hF;
    rnd_st = 32'h0000_005C;
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    setup(7'h00, 1, 1, 1);
    foreach (bad[i]) begin
      wr(ADDR_CFG, {25'h0, bad[i]}, r);
      chk(r, RESP_SLVERR, "hold cfg refused");
    end
    rd(ADDR_CFG, d, r);
    chk(d, 32'h0, "cfg kept");
    rd(ADDR_STATUS, d, r);
    chk(d[5], 1'h1, "cfg error flag");
    rd(8'h18, d, r);
    chk(d, 32'h0, "unmapped read data");
    chk(r, RESP_SLVERR, "unmapped read");
    // Lane 0 is the only byte that gates a register write
    wstrb <= 4'(xs()) & 4'hE;
    wr(ADDR_T1, 32'h0000_0055, r);
    wstrb <= 4'hF;
    rd(ADDR_T1, d, r);
    chk(d, 32'h1, "write without lane 0 ignored");
    done("config");
    setup(7'h00, 1, 1, 1);
    panel_u.set_switch(1'h0);
    panel_u.press(0);
    repeat (5) @(negedge aclk);
    chk({scan_stage, cell_enable}, 4'h0, "switch off");
    panel_u.set_switch(1'h1);
    done("switch");
    for (int k = 0; k < 2; k++) begin
      t1 = 1 + xs() % 3;
      t2 = 1 + xs() % 3;
      setup(k ? 7'h10 : 7'h00, t1, t2, 1);
      panel_u.press(0);
      run(0, 0, k[0], 3, 3'h0, t1);
      if (k == 1) stop_chk();
    end
    done("step single");
    setup(7'h20, 3, 3, 1);
    panel_u.press(0);
    run(0, 1, 0, 3, 3'h0, 3);
    panel_u.press(1);
    repeat (4 * STEP_TICK_CYC) @(negedge aclk);
    chk({29'h0, scan_stage}, 2, "paused");
    rd(ADDR_STATUS, d, r);
    chk(d[5:0], 6'h1A, "pause status");
    panel_u.press(1);
    run(0, 1, 0, 1, 3'h2, -1);
    stop_chk();
    done("step continuous");
    setup(7'h40, 1, 1, 1);
    panel_u.press(0);
    repeat (3) @(negedge aclk);
    chk({scan_stage, cell_enable}, 4'h3, "armed");
    repeat (30) @(negedge aclk);
    chk({29'h0, scan_stage}, 1, "waits for trigger");
    panel_u.fire_trig();
    run(0, 0, 0, 1, 3'h1, -1);
    stop_chk();
    done("external");
    setup(7'h00, 1, 1, 1);
    wr(ADDR_CMD, 32'h0000_0010, r);
    run(0, 0, 0, 1, 3'h0, -1);
    wr(ADDR_CMD, 32'h0000_0008, r);
    @(negedge aclk);
    chk({scan_stage, cell_enable}, 4'h0, "remote stop");
    setup(7'h02, 1, 1, 1);
    wr(ADDR_CMD, 32'h0000_0001, r);
    run(2, 0, 0, 2, 3'h0, -1);
    setup(7'h01, 1, 1, 1);
    panel_u.press(0);
    repeat (2700) @(negedge aclk);
    chk({scan_stage, cell_enable}, 4'h5, "plain hold stays");
    panel_u.press(2);
    @(negedge aclk);
    chk({scan_stage, cell_enable}, 4'h0, "hold ends open circuit");
    done("remote and timed hold");
    setup(7'h0B, 1, 1, 1);
    chk(current_control, 1'h1, "galvanostat");
    panel_u.press(0);
    run(3, 0, 0, 1, 3'h0, -1);
    panel_u.press(2);
    run(3, 0, 0, 1, 3'h3, -1);
    panel_u.press(2);
    run(3, 0, 0, 1, 3'h5, -1);
    setup(7'h13, 1, 1, 1);
    chk(current_control, 1'h0, "potentiostat");
    panel_u.press(0);
    run(3, 0, 1, 3, 3'h0, -1);
    stop_chk();
    setup(7'h23, 1, 1, 1);
    panel_u.press(0);
    run(3, 1, 0, 3, 3'h0, -1);
    stop_chk();
    setup(7'h24, 1, 1, 1);
    panel_u.press(0);
    run(4, 1, 0, 5, 3'h0, -1);
    stop_chk();
    done("ramps");
    conclude();
  end
endmodule
